// ==== hw/misc_control_registers.sv ====
// miscellaneous control register bank behind an axi4-lite slave
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module misc_control_registers
   import misc_ctrl_pkg::*;
#(
   parameter int NUM_INT = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NUM_INT-1:0] int_events,
   input wire macro_req_t macro_req,
   output logic audio_reset,
   output logic touch_reset,
   output logic copro_reset,
   output logic display_enable_dir,
   output logic general_pin_one_dir,
   output logic general_pin_zero_dir,
   output logic backlight_pwm_out,
   output logic dl_write,
   output logic [31:0] dl_word,
   output logic irq
);
   typedef struct packed {
      logic aw_got;
      logic w_got;
      reg_access_t wr;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [2:0] engine;
      logic [7:0] pin_dir;
      logic [NUM_INT-1:0] flags;
      logic int_global;
      logic [NUM_INT-1:0] mask;
      logic [13:0] bl_freq;
      logic [7:0] bl_duty;
      logic [31:0] macro_zero;
      logic [31:0] macro_one;
      logic irq;
   } bank_state_t;
   bank_state_t st_reg, st_next;
   logic do_write;
   logic do_read;
   logic [31:0] wval;
   logic [31:0] old;
   logic wr_ok;
   logic [NUM_INT-1:0] clr_bits;
   logic [NUM_INT-1:0] flags_next_v;

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = n[i*8 +: 8];
         end
      end
      return r;
   endfunction

   always_comb begin
      st_next = st_reg;
      old = 32'h0;
      wr_ok = 1'b1;
      clr_bits = '0;
      // address and data taken in either order, held until both are in
      if (s_axi_awvalid && !st_reg.aw_got) begin
         st_next.aw_got = 1'b1;
         st_next.wr.addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_reg.w_got) begin
         st_next.w_got = 1'b1;
         st_next.wr.data = s_axi_wdata;
         st_next.wstrb = s_axi_wstrb;
      end
      do_write = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
      case (st_reg.wr.addr)
         OFS_ENGINE_RESET: old = {29'h0, st_reg.engine};
         OFS_PIN_DIR: old = {24'h0, st_reg.pin_dir};
         OFS_INT_GLOBAL: old = {31'h0, st_reg.int_global};
         OFS_INT_MASK: old = 32'(st_reg.mask);
         OFS_BL_FREQ: old = {18'h0, st_reg.bl_freq};
         OFS_BL_DUTY: old = {24'h0, st_reg.bl_duty};
         OFS_MACRO_ZERO: old = st_reg.macro_zero;
         OFS_MACRO_ONE: old = st_reg.macro_one;
         default: old = 32'h0;
      endcase
      wval = merge(old, st_reg.wr.data, st_reg.wstrb);
      if (do_write) begin
         st_next.aw_got = 1'b0;
         st_next.w_got = 1'b0;
         st_next.bvalid = 1'b1;
         case (st_reg.wr.addr)
            OFS_ENGINE_RESET: st_next.engine = wval[2:0];
            OFS_PIN_DIR: st_next.pin_dir = {wval[DIR_DISPLAY_BIT], 5'h00, wval[DIR_GP1_BIT], wval[DIR_GP0_BIT]};
            OFS_INT_GLOBAL: st_next.int_global = wval[0];
            OFS_INT_MASK: st_next.mask = wval[NUM_INT-1:0];
            OFS_INT_CLEAR: clr_bits = wval[NUM_INT-1:0];
            // frequency field stored unchecked; pwm clamps below BL_FREQ_MIN, above BL_FREQ_MAX left to software
            OFS_BL_FREQ: st_next.bl_freq = wval[13:0];
            OFS_BL_DUTY: st_next.bl_duty = wval[7:0];
            OFS_MACRO_ZERO: st_next.macro_zero = wval;
            OFS_MACRO_ONE: st_next.macro_one = wval;
            OFS_INT_FLAGS: wr_ok = 1'b0;
            default: wr_ok = 1'b0;
         endcase
         st_next.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
      end
      do_read = s_axi_arvalid && !st_reg.rvalid;
      if (do_read) begin
         st_next.rvalid = 1'b1;
         st_next.rresp = RESP_OKAY;
         case (s_axi_araddr)
            OFS_ENGINE_RESET: st_next.rdata = {29'h0, st_reg.engine};
            OFS_PIN_DIR: st_next.rdata = {24'h0, st_reg.pin_dir};
            OFS_INT_FLAGS: st_next.rdata = 32'(st_reg.flags);
            OFS_INT_GLOBAL: st_next.rdata = {31'h0, st_reg.int_global};
            OFS_INT_MASK: st_next.rdata = 32'(st_reg.mask);
            OFS_INT_CLEAR: st_next.rdata = 32'h0;
            OFS_BL_FREQ: st_next.rdata = {18'h0, st_reg.bl_freq};
            OFS_BL_DUTY: st_next.rdata = {24'h0, st_reg.bl_duty};
            OFS_MACRO_ZERO: st_next.rdata = st_reg.macro_zero;
            OFS_MACRO_ONE: st_next.rdata = st_reg.macro_one;
            default: begin
               st_next.rdata = 32'h0;
               st_next.rresp = RESP_SLVERR;
            end
         endcase
      end
      if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end
      // read clears flags, new events win
      flags_next_v = st_reg.flags;
      if (do_read && s_axi_araddr == OFS_INT_FLAGS) begin
         flags_next_v = '0;
      end
      flags_next_v = (flags_next_v & ~clr_bits) | int_events;
      st_next.flags = flags_next_v;
      st_next.irq = st_reg.int_global && |(st_reg.flags & st_reg.mask);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= '0;
         st_reg.mask <= RST_INT_MASK[NUM_INT-1:0];
         st_reg.engine <= RST_ENGINE;
         st_reg.pin_dir <= RST_PIN_DIR;
         st_reg.int_global <= RST_INT_GLOBAL;
         st_reg.bl_freq <= RST_BL_FREQ;
         st_reg.bl_duty <= RST_BL_DUTY;
      end else begin
         st_reg <= st_next;
      end
   end

   // ready only while the channel is not yet latched; this gives back-pressure
   assign s_axi_awready = !st_reg.aw_got;
   assign s_axi_wready = !st_reg.w_got;
   assign s_axi_arready = !st_reg.rvalid;
   assign s_axi_bvalid = st_reg.bvalid;
   assign s_axi_bresp = st_reg.bresp;
   assign s_axi_rvalid = st_reg.rvalid;
   assign s_axi_rdata = st_reg.rdata;
   assign s_axi_rresp = st_reg.rresp;
   assign audio_reset = st_reg.engine[ENG_AUDIO_BIT];
   assign touch_reset = st_reg.engine[ENG_TOUCH_BIT];
   assign copro_reset = st_reg.engine[ENG_COPRO_BIT];
   assign display_enable_dir = st_reg.pin_dir[DIR_DISPLAY_BIT];
   assign general_pin_one_dir = st_reg.pin_dir[DIR_GP1_BIT];
   assign general_pin_zero_dir = st_reg.pin_dir[DIR_GP0_BIT];
   assign irq = st_reg.irq;

   backlight_pwm #(
      .STEPS(128)
   ) u_pwm (
      .aclk(aclk),
      .aresetn(aresetn),
      .freq_hz(st_reg.bl_freq),
      .duty(st_reg.bl_duty),
      .pwm_out(backlight_pwm_out)
   );

   macro_substitute u_macro (
      .aclk(aclk),
      .aresetn(aresetn),
      .macro_req(macro_req),
      .macro_zero(st_reg.macro_zero),
      .macro_one(st_reg.macro_one),
      .dl_write(dl_write),
      .dl_word(dl_word)
   );

   sequence s_eng_write(int b);
      do_write && st_reg.wr.addr == OFS_ENGINE_RESET && st_reg.wstrb[0] && st_reg.wr.data[b];
   endsequence
   property p_eng_hold;
      @(posedge aclk) disable iff (!aresetn) s_eng_write(ENG_AUDIO_BIT) |=> audio_reset;
   endproperty
   a_eng_hold: assert property (p_eng_hold) else $error("audio not held in reset");
   property p_eng_release;
      @(posedge aclk) disable iff (!aresetn)
         (do_write && st_reg.wr.addr == OFS_ENGINE_RESET && st_reg.wstrb[0] && !st_reg.wr.data[ENG_COPRO_BIT])
         |=> !copro_reset;
   endproperty
   a_eng_release: assert property (p_eng_release) else $error("coprocessor not released");
   property p_eng_read;
      @(posedge aclk) disable iff (!aresetn)
         (do_read && s_axi_araddr == OFS_ENGINE_RESET)
         |=> (s_axi_rdata[2:0] == {$past(audio_reset), $past(touch_reset), $past(copro_reset)});
   endproperty
   a_eng_read: assert property (p_eng_read) else $error("engine reset readback wrong");
   property p_mask_reset;
      @(posedge aclk) $rose(aresetn) |-> (st_reg.mask == RST_INT_MASK[NUM_INT-1:0] && st_reg.bl_freq == RST_BL_FREQ);
   endproperty
   a_mask_reset: assert property (p_mask_reset) else $error("mask or frequency reset value wrong");
   property p_global_block;
      @(posedge aclk) disable iff (!aresetn) !st_reg.int_global |=> !irq;
   endproperty
   a_global_block: assert property (p_global_block) else $error("irq while globally disabled");
   property p_mask_gate;
      @(posedge aclk) disable iff (!aresetn) (st_reg.int_global && |(st_reg.flags & st_reg.mask)) |=> irq;
   endproperty
   a_mask_gate: assert property (p_mask_gate) else $error("enabled flag gave no irq");
   property p_masked_quiet;
      @(posedge aclk) disable iff (!aresetn) ((st_reg.flags & st_reg.mask) == '0) |=> !irq;
   endproperty
   a_masked_quiet: assert property (p_masked_quiet) else $error("irq from masked source");
   property p_read_clear;
      @(posedge aclk) disable iff (!aresetn)
         (do_read && s_axi_araddr == OFS_INT_FLAGS && int_events == '0) |=> (st_reg.flags == '0);
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("flags not cleared by read");
   property p_dir;
      @(posedge aclk) disable iff (!aresetn)
         (do_write && st_reg.wr.addr == OFS_PIN_DIR && st_reg.wstrb[0])
         |=> (display_enable_dir == $past(st_reg.wr.data[DIR_DISPLAY_BIT]));
   endproperty
   a_dir: assert property (p_dir) else $error("display enable direction wrong");
   sequence s_lands(logic [7:0] a);
      do_write && st_reg.wr.addr == a && st_reg.wstrb == 4'hF;
   endsequence
   property p_touch_hold;
      @(posedge aclk) disable iff (!aresetn) s_eng_write(ENG_TOUCH_BIT) |=> touch_reset;
   endproperty
   a_touch_hold: assert property (p_touch_hold) else $error("touch not held in reset");
   property p_copro_hold;
      @(posedge aclk) disable iff (!aresetn) s_eng_write(ENG_COPRO_BIT) |=> copro_reset;
   endproperty
   a_copro_hold: assert property (p_copro_hold) else $error("coprocessor not held in reset");
   property p_gp_dir;
      @(posedge aclk) disable iff (!aresetn)
         s_lands(OFS_PIN_DIR) |=> {general_pin_one_dir, general_pin_zero_dir} == $past(st_reg.wr.data[1:0]);
   endproperty
   a_gp_dir: assert property (p_gp_dir) else $error("general pin direction wrong");
   property p_duty_store;
      @(posedge aclk) disable iff (!aresetn)
         s_lands(OFS_BL_DUTY) |=> st_reg.bl_duty == $past(st_reg.wr.data[7:0]);
   endproperty
   a_duty_store: assert property (p_duty_store) else $error("duty not stored");
   property p_duty_full;
      @(posedge aclk) disable iff (!aresetn)
         (st_reg.bl_duty >= BL_DUTY_MAX) ##1 (st_reg.bl_duty >= BL_DUTY_MAX) |-> backlight_pwm_out;
   endproperty
   a_duty_full: assert property (p_duty_full) else $error("backlight not full at max duty");
   property p_freq_store;
      @(posedge aclk) disable iff (!aresetn)
         s_lands(OFS_BL_FREQ) |=> st_reg.bl_freq == $past(st_reg.wr.data[13:0]);
   endproperty
   a_freq_store: assert property (p_freq_store) else $error("frequency not stored");
   property p_global_store;
      @(posedge aclk) disable iff (!aresetn)
         s_lands(OFS_INT_GLOBAL) |=> st_reg.int_global == $past(st_reg.wr.data[0]);
   endproperty
   a_global_store: assert property (p_global_store) else $error("global enable not stored");
   property p_mask_store;
      @(posedge aclk) disable iff (!aresetn)
         s_lands(OFS_INT_MASK) |=> st_reg.mask == $past(st_reg.wr.data[NUM_INT-1:0]);
   endproperty
   a_mask_store: assert property (p_mask_store) else $error("mask not stored");
   property p_macro_zero_store;
      @(posedge aclk) disable iff (!aresetn)
         s_lands(OFS_MACRO_ZERO) |=> st_reg.macro_zero == $past(st_reg.wr.data);
   endproperty
   a_macro_zero_store: assert property (p_macro_zero_store) else $error("macro zero not stored");
   property p_macro_one_store;
      @(posedge aclk) disable iff (!aresetn)
         s_lands(OFS_MACRO_ONE) |=> st_reg.macro_one == $past(st_reg.wr.data);
   endproperty
   a_macro_one_store: assert property (p_macro_one_store) else $error("macro one not stored");
   property p_flags_refused;
      @(posedge aclk) disable iff (!aresetn)
         (do_write && st_reg.wr.addr == OFS_INT_FLAGS) |=> s_axi_bresp == RESP_SLVERR;
   endproperty
   a_flags_refused: assert property (p_flags_refused) else $error("flag write not refused");
   sequence s_flag_read;
      do_read && s_axi_araddr == OFS_INT_FLAGS;
   endsequence
   property p_flag_data;
      @(posedge aclk) disable iff (!aresetn) s_flag_read |=> s_axi_rdata == 32'($past(st_reg.flags));
   endproperty
   a_flag_data: assert property (p_flag_data) else $error("flag read data wrong");
   // per flag, set wins
   // an event in the read cycle must survive the clear
   for (genvar i = 0; i < NUM_INT; i++) begin : g_flag
      property p_flag_set;
         @(posedge aclk) disable iff (!aresetn) int_events[i] |=> st_reg.flags[i];
      endproperty
      a_flag_set: assert property (p_flag_set) else $error("event lost from flag");
      property p_flag_sticky;
         @(posedge aclk) disable iff (!aresetn)
            (st_reg.flags[i] && !do_read && !(do_write && st_reg.wr.addr == OFS_INT_CLEAR)) |=> st_reg.flags[i];
      endproperty
      a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without clear");
   end
endmodule

// ==== hw/misc_ctrl_pkg.sv ====
// package: register map, field layout, reset values and carrier structs
package misc_ctrl_pkg;
   localparam logic [7:0] OFS_ENGINE_RESET = 8'h20;
   localparam logic [7:0] OFS_PIN_DIR = 8'h90;
   localparam logic [7:0] OFS_INT_FLAGS = 8'hA8;
   localparam logic [7:0] OFS_INT_GLOBAL = 8'hAC;
   localparam logic [7:0] OFS_INT_MASK = 8'hB0;
   localparam logic [7:0] OFS_INT_CLEAR = 8'hB4;
   localparam logic [7:0] OFS_BL_FREQ = 8'hD0;
   localparam logic [7:0] OFS_BL_DUTY = 8'hD4;
   localparam logic [7:0] OFS_MACRO_ZERO = 8'hD8;
   localparam logic [7:0] OFS_MACRO_ONE = 8'hDC;
   localparam int ENG_AUDIO_BIT = 2;
   localparam int ENG_TOUCH_BIT = 1;
   localparam int ENG_COPRO_BIT = 0;
   localparam int DIR_DISPLAY_BIT = 7;
   localparam int DIR_GP1_BIT = 1;
   localparam int DIR_GP0_BIT = 0;
   localparam logic [2:0] RST_ENGINE = 3'h0;
   localparam logic [7:0] RST_PIN_DIR = 8'h00;
   localparam logic [7:0] RST_INT_MASK = 8'hFF;
   localparam logic RST_INT_GLOBAL = 1'b0;
   localparam logic [13:0] RST_BL_FREQ = 14'h00FA;
   localparam logic [7:0] RST_BL_DUTY = 8'h80;
   localparam logic [7:0] BL_DUTY_MAX = 8'h80;
   localparam logic [13:0] BL_FREQ_MIN = 14'h00FA;
   localparam logic [13:0] BL_FREQ_MAX = 14'h2710;
   localparam int CLK_HZ = 40000000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
   } reg_access_t;

   typedef struct packed {
      logic req;
      logic sel_one;
   } macro_req_t;
endpackage

// ==== hw/backlight_pwm.sv ====
// backlight pwm generator with frequency divider enable
`timescale 1ns/1ps
module backlight_pwm
   import misc_ctrl_pkg::*;
#(
   parameter int STEPS = 128
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [13:0] freq_hz,
   input wire logic [7:0] duty,
   output logic pwm_out
);
   typedef struct packed {
      logic [31:0] div;
      logic [7:0] phase;
      logic out;
   } pwm_state_t;
   pwm_state_t st_reg, st_next;
   logic [31:0] tick_div;

   // one step enable per 1/(freq*128) s; zero freq guarded by clamp
   always_comb begin
      tick_div = 32'(CLK_HZ / ((freq_hz < BL_FREQ_MIN ? 32'(BL_FREQ_MIN) : 32'(freq_hz)) * STEPS));
      st_next = st_reg;
      if (st_reg.div + 32'h1 >= tick_div) begin
         st_next.div = 32'h0;
         st_next.phase = (st_reg.phase >= 8'(STEPS - 1)) ? 8'h00 : st_reg.phase + 8'h01;
      end else begin
         st_next.div = st_reg.div + 32'h1;
      end
      st_next.out = (duty >= BL_DUTY_MAX) ? 1'b1 : (st_reg.phase < duty);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign pwm_out = st_reg.out;

   property p_duty_off;
      @(posedge aclk) disable iff (!aresetn) (duty == 8'h00) ##1 (duty == 8'h00) |-> !pwm_out;
   endproperty
   a_duty_off: assert property (p_duty_off) else $error("backlight on at zero duty");
endmodule

// ==== hw/macro_substitute.sv ====
// macro substitution: picks macro word for display list memory write
`timescale 1ns/1ps
module macro_substitute
   import misc_ctrl_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire macro_req_t macro_req,
   input wire logic [31:0] macro_zero,
   input wire logic [31:0] macro_one,
   output logic dl_write,
   output logic [31:0] dl_word
);
   typedef struct packed {
      logic wr;
      logic [31:0] word;
   } sub_state_t;
   sub_state_t st_reg, st_next;

   always_comb begin
      st_next.wr = macro_req.req;
      st_next.word = st_reg.word;
      if (macro_req.req) begin
         st_next.word = macro_req.sel_one ? macro_one : macro_zero;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign dl_write = st_reg.wr;
   assign dl_word = st_reg.word;

   property p_sel_one;
      @(posedge aclk) disable iff (!aresetn) (macro_req.req && macro_req.sel_one) |=> (dl_word == $past(macro_one));
   endproperty
   a_sel_one: assert property (p_sel_one) else $error("macro one not substituted");
   property p_sel_zero;
      @(posedge aclk) disable iff (!aresetn) (macro_req.req && !macro_req.sel_one) |=> (dl_word == $past(macro_zero));
   endproperty
   a_sel_zero: assert property (p_sel_zero) else $error("macro zero not substituted");
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the misc control register bank
`timescale 1ns/1ps
module tb;
   import misc_ctrl_pkg::*;
   logic aclk, aresetn;
   logic [7:0] s_axi_awaddr, s_axi_araddr, int_events;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, dl_word;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   macro_req_t macro_req;
   logic audio_reset, touch_reset, copro_reset, display_enable_dir, general_pin_one_dir, general_pin_zero_dir;
   logic backlight_pwm_out, dl_write, irq;
   int miscompares = 0;
   int num_checks = 0;

   misc_control_registers u_misc_control_registers (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .int_events(int_events),
      .macro_req(macro_req), .audio_reset(audio_reset), .touch_reset(touch_reset),
      .copro_reset(copro_reset), .display_enable_dir(display_enable_dir),
      .general_pin_one_dir(general_pin_one_dir), .general_pin_zero_dir(general_pin_zero_dir),
      .backlight_pwm_out(backlight_pwm_out), .dl_write(dl_write), .dl_word(dl_word), .irq(irq));

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   task automatic close_out();
      $display("checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // master write; the slave may take address and data on different edges
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp_resp);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            s_axi_bready <= 1'b0;
            check(32'(s_axi_bresp), 32'(exp_resp));
            break;
         end
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            s_axi_rready <= 1'b0;
            check(s_axi_rdata, exp);
            check(32'(s_axi_rresp), 32'(exp_resp));
            break;
         end
      end
   endtask

   task automatic t_reset_values();
      rd(OFS_ENGINE_RESET, 32'h0000_0000, RESP_OKAY);
      rd(OFS_PIN_DIR, 32'h0000_0000, RESP_OKAY);
      rd(OFS_INT_MASK, 32'h0000_00FF, RESP_OKAY);
      rd(OFS_BL_FREQ, 32'h0000_00FA, RESP_OKAY);
      rd(OFS_BL_DUTY, 32'h0000_0080, RESP_OKAY);
      rd(OFS_INT_FLAGS, 32'h0000_0000, RESP_OKAY);
      rd(OFS_MACRO_ONE, 32'h0000_0000, RESP_OKAY);
      rd(OFS_MACRO_ZERO, 32'h0000_0000, RESP_OKAY);
      rd(OFS_INT_GLOBAL, 32'h0000_0000, RESP_OKAY);
   endtask

   task automatic t_engine();
      for (int i = 0; i < 3; i++) begin
         wr(OFS_ENGINE_RESET, 32'(1 << i), RESP_OKAY);
         check(32'({audio_reset, touch_reset, copro_reset}), 32'(1 << i));
         rd(OFS_ENGINE_RESET, 32'(1 << i), RESP_OKAY);
      end
      wr(OFS_ENGINE_RESET, 32'h0000_0000, RESP_OKAY);
      check(32'({audio_reset, touch_reset, copro_reset}), 32'h0000_0000);
   endtask

   task automatic t_pin_dir();
      wr(OFS_PIN_DIR, 32'hFFFF_FFFF, RESP_OKAY);
      check(32'({display_enable_dir, general_pin_one_dir, general_pin_zero_dir}), 32'h0000_0007);
      rd(OFS_PIN_DIR, 32'h0000_0083, RESP_OKAY);
      wr(OFS_PIN_DIR, 32'h0000_0002, RESP_OKAY);
      check(32'({display_enable_dir, general_pin_one_dir, general_pin_zero_dir}), 32'h0000_0002);
   endtask

   // dl_write is a one-cycle pulse one cycle after the request
   task automatic macro_chk(input logic sel, input logic [31:0] exp);
      @(posedge aclk);
      macro_req <= '{req: 1'b1, sel_one: sel};
      @(posedge aclk);
      macro_req <= '{req: 1'b0, sel_one: 1'b0};
      @(posedge aclk);
      check(32'(dl_write), 32'h0000_0001);
      check(dl_word, exp);
      @(posedge aclk);
      check(32'(dl_write), 32'h0000_0000);
   endtask

   task automatic t_macro();
      wr(OFS_MACRO_ZERO, 32'h1122_3344, RESP_OKAY);
      wr(OFS_MACRO_ONE, 32'hA5A5_5A5A, RESP_OKAY);
      macro_chk(1'b1, 32'hA5A5_5A5A);
      macro_chk(1'b0, 32'h1122_3344);
      // byte lane 1 only: the rest of the word must survive
      s_axi_wstrb <= 4'h2;
      wr(OFS_MACRO_ZERO, 32'h0000_0000, RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      rd(OFS_MACRO_ZERO, 32'h1122_0044, RESP_OKAY);
      macro_chk(1'b0, 32'h1122_0044);
   endtask

   task automatic pulse(input logic [7:0] v);
      @(posedge aclk);
      int_events <= v;
      @(posedge aclk);
      int_events <= 8'h00;
   endtask

   task automatic irq_chk(input logic exp);
      repeat (3) @(posedge aclk);
      check(32'(irq), 32'(exp));
   endtask

   task automatic t_irq();
      pulse(8'h08);
      irq_chk(1'b0);
      wr(OFS_INT_GLOBAL, 32'h0000_0001, RESP_OKAY);
      irq_chk(1'b1);
      wr(OFS_INT_MASK, 32'h0000_00F7, RESP_OKAY);
      irq_chk(1'b0);
      wr(OFS_INT_MASK, 32'h0000_00FF, RESP_OKAY);
      irq_chk(1'b1);
      rd(OFS_INT_FLAGS, 32'h0000_0008, RESP_OKAY);
      irq_chk(1'b0);
      rd(OFS_INT_FLAGS, 32'h0000_0000, RESP_OKAY);
      pulse(8'hFF);
      wr(OFS_INT_CLEAR, 32'h0000_000F, RESP_OKAY);
      rd(OFS_INT_FLAGS, 32'h0000_00F0, RESP_OKAY);
      wr(OFS_INT_FLAGS, 32'h0000_00FF, RESP_SLVERR);
   endtask

   // event lands in the very cycle the flag read is taken
   task automatic t_set_wins();
      @(posedge aclk);
      s_axi_araddr <= OFS_INT_FLAGS;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      int_events <= 8'h01;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      int_events <= 8'h00;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      s_axi_rready <= 1'b0;
      check(32'(s_axi_rresp), 32'(RESP_OKAY));
      rd(OFS_INT_FLAGS, 32'h0000_0001, RESP_OKAY);
   endtask

   // unmapped place: refused, no side effect
   task automatic t_errors();
      wr(8'h44, 32'hDEAD_BEEF, RESP_SLVERR);
      rd(8'h44, 32'h0000_0000, RESP_SLVERR);
   endtask

   // at 10000 Hz a pwm period is about 4000 clocks
   task automatic pwm_count(input logic [7:0] d, output int cnt);
      wr(OFS_BL_DUTY, 32'(d), RESP_OKAY);
      repeat (4500) @(posedge aclk);
      cnt = 0;
      repeat (8000) begin
         @(posedge aclk);
         if (backlight_pwm_out === 1'b1) cnt++;
      end
   endtask

   task automatic t_pwm();
      int cnt;
      wr(OFS_BL_FREQ, 32'h0000_2710, RESP_OKAY);
      rd(OFS_BL_FREQ, 32'h0000_2710, RESP_OKAY);
      pwm_count(8'h00, cnt);
      check(32'(cnt), 32'h0000_0000);
      pwm_count(BL_DUTY_MAX, cnt);
      check(32'(cnt), 32'(8000));
      pwm_count(8'h40, cnt);
      check(32'(cnt > 3000 && cnt < 5000), 32'h0000_0001);
   endtask

   initial begin
      repeat (80000) @(posedge aclk);
      miscompares++;
      close_out();
   end

   initial begin
      aresetn = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      int_events = 8'h00;
      macro_req = '{req: 1'b0, sel_one: 1'b0};
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset_values();
      t_engine();
      t_pin_dir();
      t_macro();
      t_irq();
      t_set_wins();
      t_errors();
      t_pwm();
      close_out();
   end
endmodule
